// ===== dual_wiper_pkg.sv
// Shared constants and types for the dual wiper command unit
package dual_wiper_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS       = 8;
  localparam int NV_WRITE_TIME_MS    = 10;
  localparam int NV_WRITE_CYCLES     = NV_WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WIPER_SETTLE_NS     = 1000;
  localparam int WIPER_SETTLE_CYCLES =
    (WIPER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Geometry
  localparam int POT_COUNT  = 2;
  localparam int SLOT_COUNT = 4;
  localparam int POS_WIDTH  = 8;
  localparam int TAP_COUNT  = 256;

  // Identification byte: arbitrary neutral device type code
  localparam logic [3:0] DEVICE_TYPE_CODE = 4'ha;

  // Instruction opcodes
  localparam logic [3:0] OP_RD_WIPER    = 4'h9;
  localparam logic [3:0] OP_WR_WIPER    = 4'ha;
  localparam logic [3:0] OP_RD_SLOT     = 4'hb;
  localparam logic [3:0] OP_WR_SLOT     = 4'hc;
  localparam logic [3:0] OP_SLOT2WIPER  = 4'hd;
  localparam logic [3:0] OP_WIPER2SLOT  = 4'he;
  localparam logic [3:0] OP_GSLOT2WIPER = 4'h1;
  localparam logic [3:0] OP_GWIPER2SLOT = 4'h8;
  localparam logic [3:0] OP_STEP        = 4'h2;

  // Instruction byte layout, MSB first
  typedef struct packed {
    logic [3:0] opcode;
    logic       slotSelectHi;
    logic       slotSelectLo;
    logic       zeroBit;
    logic       potSelect;
  } instr_type;

  // Serial engine states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RX   = 7'h02,
    ST_ACK  = 7'h04,
    ST_TX   = 7'h08,
    ST_MACK = 7'h10,
    ST_STEP = 7'h20,
    ST_SKIP = 7'h40
  } bus_state_type;

endpackage : dual_wiper_pkg

// ===== dual_wiper_register_command_unit.sv
// Two-wire slave command unit holding wipers and nonvolatile slots
module dual_wiper_register_command_unit
  import dual_wiper_pkg::*;
#(
  parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // Two-wire bus pins
  input  wire logic                 sclIn,
  input  wire logic                 sdaIn,
  output logic                      sdaOut,
  output logic                      sdaOe,
  // Address straps
  input  wire logic [3:0]           busAddrPins,
  // Tap switch selects and status
  output logic [TAP_COUNT-1:0]      tapSwitch0,
  output logic [TAP_COUNT-1:0]      tapSwitch1,
  output logic                      nvBusy
);
  import dual_wiper_pkg::*;

  localparam int BUSY_W = $clog2(NV_CYCLES + 1);
  localparam int SET_W  = $clog2(WIPER_SETTLE_CYCLES + 1);

  if (NV_CYCLES < 1) begin : g_bad_cycles
    $error("NV_CYCLES must be at least one");
  end

  // Storage
  logic [7:0] wiper_r [POT_COUNT];
  logic [7:0] slot_r  [POT_COUNT][SLOT_COUNT];
  logic [7:0] tapPos_r [POT_COUNT];
  logic       recallDone_r;

  // Pin synchronisers; only the second and third stage are inspected
  logic [2:0] sclSync_r;
  logic [2:0] sdaSync_r;
  logic       sclF_r;
  logic       sdaF_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclSync_r <= 3'h7;
      sdaSync_r <= 3'h7;
    end else begin
      sclSync_r <= {sclSync_r[1:0], sclIn};
      sdaSync_r <= {sdaSync_r[1:0], sdaIn};
    end
  end

  wire sclAgree = sclSync_r[1] == sclSync_r[2];
  wire sdaAgree = sdaSync_r[1] == sdaSync_r[2];
  wire sclRise  = sclAgree && sclSync_r[2] && !sclF_r;
  wire sclFall  = sclAgree && !sclSync_r[2] && sclF_r;
  wire sdaRise  = sdaAgree && sdaSync_r[2] && !sdaF_r;
  wire sdaFall  = sdaAgree && !sdaSync_r[2] && sdaF_r;
  // Start and stop only count while the clock sits high and steady
  wire startEv  = sdaFall && sclF_r && !sclFall;
  wire stopEv   = sdaRise && sclF_r && !sclFall;

  // Filtered levels move only when the last two stages agree
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclF_r <= 1'b1;
      sdaF_r <= 1'b1;
    end else begin
      if (sclAgree) sclF_r <= sclSync_r[2];
      if (sdaAgree) sdaF_r <= sdaSync_r[2];
    end
  end

  // Serial engine registers
  bus_state_type state_r;
  logic [7:0]    shReg_r;
  logic [7:0]    txReg_r;
  logic [2:0]    bitCnt_r;
  logic [1:0]    byteIdx_r;
  logic          ackPend_r;
  instr_type     instr_r;
  logic          nvPend_r;
  logic [1:0]    nvMask_r;
  logic [1:0]    nvIdx_r;
  logic [7:0]    nvData_r [POT_COUNT];
  logic [BUSY_W-1:0] busyCnt_r;

  // Byte decode
  wire [7:0]  rxByte   = {shReg_r[6:0], sdaF_r};
  instr_type  rxInstr;
  assign rxInstr = instr_type'(rxByte);
  wire        byteDone = (state_r == ST_RX) && sclRise && (bitCnt_r == 3'h7);
  wire        addrHit  = (rxByte == {DEVICE_TYPE_CODE, busAddrPins})
                         && !nvBusy;
  wire        opValid  = (rxInstr.opcode == OP_RD_WIPER)
                      || (rxInstr.opcode == OP_WR_WIPER)
                      || (rxInstr.opcode == OP_RD_SLOT)
                      || (rxInstr.opcode == OP_WR_SLOT)
                      || (rxInstr.opcode == OP_SLOT2WIPER)
                      || (rxInstr.opcode == OP_WIPER2SLOT)
                      || (rxInstr.opcode == OP_GSLOT2WIPER)
                      || (rxInstr.opcode == OP_GWIPER2SLOT)
                      || (rxInstr.opcode == OP_STEP);
  wire        ackThis  = (byteIdx_r == 2'h0) ? addrHit :
                         (byteIdx_r == 2'h1) ? opValid : 1'b1;
  wire        ackExit  = (state_r == ST_ACK) && sclFall;
  wire [1:0]  slotIdx  = {instr_r.slotSelectHi, instr_r.slotSelectLo};
  wire        potSel   = instr_r.potSelect;
  wire [7:0]  wiperSel = wiper_r[potSel];
  wire [3:0]  op       = instr_r.opcode;
  wire        instrEnd = ackExit && (byteIdx_r == 2'h1);
  wire        dataEnd  = ackExit && (byteIdx_r == 2'h2);
  wire        isGlobal = (op == OP_GSLOT2WIPER) || (op == OP_GWIPER2SLOT);
  wire [1:0]  potMask  = isGlobal ? 2'h3 : (potSel ? 2'h2 : 2'h1);
  wire        stepEv   = (state_r == ST_STEP) && sclRise;

  // Open drain: only ever pull low; release for ones
  assign sdaOut = 1'b0;
  assign sdaOe  = (state_r == ST_ACK)
               || ((state_r == ST_TX) && !txReg_r[7]);
  assign nvBusy = busyCnt_r != '0;

  // Bus engine: start restarts anywhere, stop aborts anywhere
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r   <= ST_IDLE;
      shReg_r   <= 8'h00;
      txReg_r   <= 8'h00;
      bitCnt_r  <= 3'h0;
      byteIdx_r <= 2'h0;
      ackPend_r <= 1'b0;
      instr_r   <= '0;
    end else if (startEv && recallDone_r) begin
      state_r   <= ST_RX;
      bitCnt_r  <= 3'h0;
      byteIdx_r <= 2'h0;
      ackPend_r <= 1'b0;
    end else if (stopEv) begin
      state_r   <= ST_IDLE;
      ackPend_r <= 1'b0;
    end else begin
      case (state_r)
        ST_RX: begin
          if (sclRise) begin
            shReg_r  <= rxByte;
            bitCnt_r <= bitCnt_r + 3'h1;
            if (byteDone) begin
              ackPend_r <= ackThis;
              if (!ackThis) state_r <= ST_SKIP;
              if (byteIdx_r == 2'h1) instr_r <= rxInstr;
            end
          end else if (sclFall && ackPend_r) begin
            ackPend_r <= 1'b0;
            state_r   <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            byteIdx_r <= byteIdx_r + 2'h1;
            bitCnt_r  <= 3'h0;
            state_r   <= ST_SKIP;
            if (byteIdx_r == 2'h0) begin
              state_r <= ST_RX;
            end else if (byteIdx_r == 2'h1) begin
              if (op == OP_RD_WIPER) begin
                txReg_r <= wiperSel;
                state_r <= ST_TX;
              end else if (op == OP_RD_SLOT) begin
                txReg_r <= slot_r[potSel][slotIdx];
                state_r <= ST_TX;
              end else if (op == OP_WR_WIPER || op == OP_WR_SLOT) begin
                state_r <= ST_RX;
              end else if (op == OP_STEP) begin
                state_r <= ST_STEP;
              end
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            txReg_r  <= {txReg_r[6:0], 1'b1};
            bitCnt_r <= bitCnt_r + 3'h1;
            if (bitCnt_r == 3'h7) state_r <= ST_MACK;
          end
        end
        ST_MACK: begin
          if (sclRise) state_r <= ST_SKIP;
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // Pending nonvolatile write, launched by the stop that ends the frame
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nvPend_r    <= 1'b0;
      nvMask_r    <= 2'h0;
      nvIdx_r     <= 2'h0;
      nvData_r[0] <= 8'h00;
      nvData_r[1] <= 8'h00;
      busyCnt_r   <= '0;
    end else begin
      if (startEv) nvPend_r <= 1'b0;
      if (instrEnd && (op == OP_WIPER2SLOT || op == OP_GWIPER2SLOT)) begin
        nvPend_r    <= 1'b1;
        nvMask_r    <= potMask;
        nvIdx_r     <= slotIdx;
        nvData_r[0] <= wiper_r[0];
        nvData_r[1] <= wiper_r[1];
      end else if (dataEnd && op == OP_WR_SLOT) begin
        nvPend_r          <= 1'b1;
        nvMask_r          <= potMask;
        nvIdx_r           <= slotIdx;
        nvData_r[potSel]  <= shReg_r;
      end
      if (stopEv && nvPend_r) begin
        nvPend_r  <= 1'b0;
        busyCnt_r <= BUSY_W'(NV_CYCLES - 1);
      end else if (nvBusy) begin
        busyCnt_r <= busyCnt_r - 1'b1;
      end
    end
  end

  // Slots are nonvolatile: never cleared by reset, stored as given
  always_ff @(posedge clock) begin
    for (int p = 0; p < POT_COUNT; p++) begin
      if (stopEv && nvPend_r && nvMask_r[p]) begin
        slot_r[p][nvIdx_r] <= nvData_r[p];
      end
    end
  end

  // Wiper loads: recall, direct write, slot transfer, stepping
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      recallDone_r <= 1'b0;
      wiper_r[0]   <= 8'h00;
      wiper_r[1]   <= 8'h00;
    end else if (!recallDone_r) begin
      recallDone_r <= 1'b1;
      for (int p = 0; p < POT_COUNT; p++) begin
        wiper_r[p] <= slot_r[p][0];
      end
    end else begin
      for (int p = 0; p < POT_COUNT; p++) begin
        if (instrEnd && potMask[p]
            && (op == OP_SLOT2WIPER || op == OP_GSLOT2WIPER)) begin
          wiper_r[p] <= slot_r[p][slotIdx];
        end else if (dataEnd && op == OP_WR_WIPER && potSel == p[0]) begin
          wiper_r[p] <= shReg_r;
        end else if (stepEv && potSel == p[0]) begin
          if (sdaF_r && wiper_r[p] != 8'hff) begin
            wiper_r[p] <= wiper_r[p] + 8'h01;
          end else if (!sdaF_r && wiper_r[p] != 8'h00) begin
            wiper_r[p] <= wiper_r[p] - 8'h01;
          end
        end
      end
    end
  end

  // Tap position follows the wiper only after the settle delay
  for (genvar g = 0; g < POT_COUNT; g++) begin : g_tap
    logic [SET_W-1:0] settle_r;
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        settle_r    <= '0;
        tapPos_r[g] <= 8'h00;
      end else if (tapPos_r[g] != wiper_r[g]) begin
        if (settle_r == SET_W'(WIPER_SETTLE_CYCLES)) begin
          settle_r    <= '0;
          tapPos_r[g] <= wiper_r[g];
        end else begin
          settle_r <= settle_r + 1'b1;
        end
      end else begin
        settle_r <= '0;
      end
    end
  end

  // One switch closed per pot
  assign tapSwitch0 = TAP_COUNT'(1) << tapPos_r[0];
  assign tapSwitch1 = TAP_COUNT'(1) << tapPos_r[1];

  // Checks
  property p_addr_ack;
    @(posedge clock) disable iff (rst)
    (state_r == ST_ACK && byteIdx_r == 2'h0)
      |-> shReg_r == {DEVICE_TYPE_CODE, busAddrPins};
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("bad address ack");

  property p_busy_nack;
    @(posedge clock) disable iff (rst)
    (nvBusy && byteDone && byteIdx_r == 2'h0) |=> state_r == ST_SKIP;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("ack while busy");

  property p_inc;
    @(posedge clock) disable iff (rst)
    (stepEv && sdaF_r && wiperSel != 8'hff && recallDone_r)
      |=> wiperSel == $past(wiperSel) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("increment missed");

  property p_dec;
    @(posedge clock) disable iff (rst)
    (stepEv && !sdaF_r && wiperSel != 8'h00 && recallDone_r)
      |=> wiperSel == $past(wiperSel) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement missed");

  property p_sat;
    @(posedge clock) disable iff (rst)
    (stepEv && sdaF_r && wiperSel == 8'hff) |=> wiperSel == 8'hff;
  endproperty
  a_sat: assert property (p_sat) else $error("wiper wrapped");

  property p_recall;
    @(posedge clock) disable iff (rst)
    !recallDone_r |=> wiper_r[0] === $past(slot_r[0][0]);
  endproperty
  a_recall: assert property (p_recall) else $error("recall wrong");

  property p_nv_len;
    @(posedge clock) disable iff (rst)
    $rose(nvBusy) |-> busyCnt_r == BUSY_W'(NV_CYCLES - 1);
  endproperty
  a_nv_len: assert property (p_nv_len) else $error("write time wrong");

  property p_settle;
    @(posedge clock) disable iff (rst)
    (recallDone_r && $changed(wiper_r[0]) && tapPos_r[0] != wiper_r[0])
      |=> tapPos_r[0] == $past(tapPos_r[0]);
  endproperty
  a_settle: assert property (p_settle) else $error("tap moved early");

  property p_onehot;
    @(posedge clock) disable iff (rst)
    $onehot(tapSwitch0) && $onehot(tapSwitch1);
  endproperty
  a_onehot: assert property (p_onehot) else $error("tap not one-hot");

endmodule : dual_wiper_register_command_unit

// ===== two_wire_host.sv
// Two-wire bus master model that drives the device pins
module two_wire_host (
  // Clock
  input  wire logic clock,
  // Bus wires, data as seen after pull-up and wired-and
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaDrv
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 8;

  // Idle bus: both wires released high, clock stands still
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  // Set both wires just after an edge, then hold for HALF clock cycles, a third of a bit period
  task automatic pin(input logic c, input logic d);
    scl <= c;
    sdaDrv <= d;
    repeat (HALF) @(posedge clock);
  endtask : pin

  // Data falls while the clock is high
  task automatic start();
    pin(scl, 1'b1);
    pin(1'b1, 1'b1);
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
  endtask : start

  // Data rises while the clock is high; in step mode it also steps down
  task automatic stop();
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
  endtask : stop

  // Data changes only while the clock is low; sampled late in the high
  task automatic xfer(input logic b, output logic s);
    pin(1'b0, b);
    pin(1'b1, b);
    s = sdaLine;
    pin(1'b0, b);
  endtask : xfer

  // Most significant bit first; the device pulls low to acknowledge
  task automatic writeByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) xfer(d[i], s);
    xfer(1'b1, s);
    ack = ~s;
  endtask : writeByte

  // Receive a byte and answer with a no-acknowledge
  task automatic readByte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(1'b1, s);
  endtask : readByte
endmodule : two_wire_host

// ===== tb_dual_wiper_register_command_unit.sv
// Self-checking bench for the dual wiper command unit
module tb_dual_wiper_register_command_unit
  import dual_wiper_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short write time keeps the run brief; polls still see it busy
  localparam int NVC   = 400;
  localparam int LIMIT = 80000;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic                 sclIn;
  logic                 sdaIn;
  logic                 sdaDrv;
  logic                 sdaOut;
  logic                 sdaOe;
  logic                 nvBusy;
  logic [3:0]           busAddrPins = 4'h0;
  logic [TAP_COUNT-1:0] tapSwitch0;
  logic [TAP_COUNT-1:0] tapSwitch1;
  logic [7:0]           idByte;
  int                   fails = 0;
  int                   n_checks = 0;
  int                   cyc = 0;
  int                   wip[2];
  int                   slt[2][4];

  always #4 clock = ~clock;
  // Open-drain data wire with pull-up
  assign sdaIn = sdaDrv & ~sdaOe;
  assign idByte = {DEVICE_TYPE_CODE, busAddrPins};

  dual_wiper_register_command_unit #(.NV_CYCLES(NVC)) u_dut (
    .clock(clock), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .busAddrPins(busAddrPins),
    .tapSwitch0(tapSwitch0), .tapSwitch1(tapSwitch1), .nvBusy(nvBusy));
  two_wire_host u_host (
    .clock(clock), .sdaLine(sdaIn), .scl(sclIn), .sdaDrv(sdaDrv));

  task automatic summarize();
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input int exp);
    n_checks++;
    if (got !== exp[7:0]) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp[7:0]);
    end
  endtask : chk

  // Address and instruction bytes; a is high only if both were acked
  task automatic cmd(input logic [3:0] op, input int s, p, output logic a);
    logic a1;
    u_host.start();
    u_host.writeByte(idByte, a1);
    u_host.writeByte({op, s[1:0], 1'b0, p[0]}, a);
    a = a & a1;
  endtask : cmd

  task automatic wr(input logic [3:0] op, input int s, p, d);
    logic a;
    cmd(op, s, p, a);
    chk({7'h00, a}, 1);
    u_host.writeByte(d[7:0], a);
    chk({7'h00, a}, 1);
    u_host.stop();
  endtask : wr

  task automatic rdc(input logic [3:0] op, input int s, p, e);
    logic a;
    logic [7:0] d;
    cmd(op, s, p, a);
    chk({7'h00, a}, 1);
    u_host.readByte(d);
    u_host.stop();
    chk(d, e);
  endtask : rdc

  // Busy after the stop; address polls refused until the write ends
  task automatic nvWait();
    logic a;
    chk({7'h00, nvBusy}, 1);
    for (int i = 0; i < 20; i++) begin
      u_host.start();
      u_host.writeByte(idByte, a);
      u_host.stop();
      if (i == 0) chk({7'h00, a}, 0);
      if (a) break;
    end
    chk({7'h00, a}, 1);
  endtask : nvWait

  // Cut a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      $display("Error at %0t: timeout", $time);
      summarize();
    end
  end

  initial begin
    int k;
    int s;
    int p;
    logic a;
    logic b;
    logic g;
    logic tw;
    logic [3:0] op;
    logic [3:0] ops[4];
    ops = '{OP_SLOT2WIPER, OP_GSLOT2WIPER, OP_WIPER2SLOT, OP_GWIPER2SLOT};
    k = $urandom(34534);
    @(posedge clock);
    busAddrPins <= 4'($urandom);
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    // Fill every slot with a random byte, then read all back
    for (k = 0; k < 8; k++) begin
      slt[k/4][k%4] = $urandom_range(255);
      wr(OP_WR_SLOT, k % 4, k / 4, slt[k/4][k%4]);
      nvWait();
    end
    for (k = 0; k < 8; k++) begin
      rdc(OP_RD_SLOT, k % 4, k / 4, slt[k/4][k%4]);
    end
    // A second reset recalls slot zero into each wiper
    rst <= 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (WIPER_SETTLE_CYCLES + 8) @(posedge clock);
    for (p = 0; p < 2; p++) begin
      wip[p] = slt[p][0];
      n_checks++;
      if ((p ? tapSwitch1 : tapSwitch0) !== (256'h1 << wip[p])) begin
        fails++;
        $display("Error at %0t: tap select wrong", $time);
      end
      rdc(OP_RD_WIPER, 0, p, wip[p]);
    end
    // Each transfer kind with fresh wipers, a random slot, and a random pot for the single-pot kinds
    for (k = 0; k < 4; k++) begin
      op = ops[k];
      g = (op == OP_GSLOT2WIPER) || (op == OP_GWIPER2SLOT);
      tw = (op == OP_SLOT2WIPER) || (op == OP_GSLOT2WIPER);
      s = $urandom_range(3);
      p = g ? 0 : $urandom_range(1);
      for (int q = 0; q < 2; q++) begin
        wip[q] = $urandom_range(255);
        wr(OP_WR_WIPER, 0, q, wip[q]);
      end
      cmd(op, s, p, a);
      chk({7'h00, a}, 1);
      u_host.stop();
      for (int q = 0; q < 2; q++) begin
        if (g || q == p) begin
          if (tw) wip[q] = slt[q][s];
          else slt[q][s] = wip[q];
        end
      end
      if (!tw) nvWait();
      for (int q = 0; q < 2; q++) begin
        rdc(OP_RD_WIPER, 0, q, wip[q]);
        rdc(OP_RD_SLOT, s, q, slt[q][s]);
      end
    end
    // Step up past the top end; the closing stop steps once down
    wr(OP_WR_WIPER, 0, 1, 254);
    cmd(OP_STEP, 0, 1, a);
    chk({7'h00, a}, 1);
    repeat (3) u_host.xfer(1'b1, b);
    u_host.stop();
    rdc(OP_RD_WIPER, 0, 1, 254);
    wr(OP_WR_WIPER, 0, 0, 1);
    cmd(OP_STEP, 0, 0, a);
    repeat (2) u_host.xfer(1'b0, b);
    u_host.stop();
    rdc(OP_RD_WIPER, 0, 0, 0);
    rdc(OP_RD_WIPER, 0, 1, 254);
    // Foreign address or type, and an unused opcode, are refused
    for (k = 0; k < 2; k++) begin
      u_host.start();
      u_host.writeByte(k ? ~idByte : {idByte[7:4], ~idByte[3:0]}, a);
      u_host.stop();
      chk({7'h00, a}, 0);
    end
    cmd(4'hf, 0, 0, a);
    u_host.stop();
    chk({7'h00, a}, 0);
    rdc(OP_RD_WIPER, 0, 0, 0);
    summarize();
  end
endmodule : tb_dual_wiper_register_command_unit
